// File: common/iofs_pkg.sv
// constants shared by the output fault supervisor design files
package iofs_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = TICK_MS_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // output geometry
  // ****************************************************************
  localparam int N_OUT = 48;
  localparam int CHIP_W = 8;
  localparam int N_CHIP = N_OUT / CHIP_W;
  localparam int N_SYNC = N_OUT + N_CHIP + 3;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_OUT_LO = 8'h00;
  localparam logic [7:0] ADDR_OUT_HI = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_SHORT_LO = 8'h10;
  localparam logic [7:0] ADDR_SHORT_HI = 8'h14;
  localparam logic [7:0] ADDR_WDT_WORK = 8'h18;
  localparam logic [7:0] ADDR_WDT_NV = 8'h1C;
  localparam logic [7:0] ADDR_RATE_NV = 8'h20;
  localparam logic [7:0] ADDR_RATE_ACT = 8'h24;
  localparam logic [7:0] ADDR_PD_LO = 8'h28;
  localparam logic [7:0] ADDR_PD_HI = 8'h2C;

  // ****************************************************************
  // fault bit positions
  // ****************************************************************
  localparam int FLT_WDOG = 0;
  localparam int FLT_SHORT = 1;
  localparam int FLT_OT = 2;
  localparam int FLT_FIELD = 3;

  // ****************************************************************
  // settings and reset values
  // ****************************************************************
  localparam logic [15:0] WDT_DEF_MS = 16'h0032;
  localparam logic [15:0] NV_RATE_DEF = 16'h0009;
  localparam logic [3:0] RATE_SETUP = 4'h4;
  localparam logic [15:0] LED_TOGGLE_UPDATES = 16'h01F4;
  localparam logic NV_IDX_TO = 1'b0;
  localparam logic NV_IDX_RATE = 1'b1;

  typedef enum logic [1:0] {
    LD_TO = 2'b00,
    LD_RATE = 2'b01,
    LD_LAST = 2'b10,
    LD_RUN = 2'b11
  } iofs_ld_e;

endpackage : iofs_pkg

// File: design/iofs_nv_store.sv
// non-volatile settings store with registered read data
`timescale 1ns/1ps
module iofs_nv_store
  import iofs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_rd_addr,
  output logic [15:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic i_wr_addr,
  input wire logic [15:0] i_wr_data
);
  // contents outlive reset like the eeprom; the initialiser is the factory image
  logic [15:0] mem_q [0:1] = '{WDT_DEF_MS, NV_RATE_DEF};

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_data <= mem_q[i_rd_addr];
    end
  end
endmodule : iofs_nv_store

// File: design/iofs_supervisor.sv
// fault supervisor of a 48-output isolated card with wishbone register access
// Contract
// - missed host access within timeout latches fault
// - fault set: output writes ignored, outputs off
// - fault flag set straight out of reset
// - short circuit disables only that output
// - chip overtemperature disables its eight outputs
// - chip groups are aligned eight-output units
// - hold 48-bit output on/off value
// - report field voltage loss with separate logic
// - power-up: activity led off, fault on
// - running: fault led off, activity blinks
// - setup mode lights both leds
// - transfer returns 48 data, 8 fault bits
// - operate link at 2.5 megabaud, 10 kHz
// - working and stored timeout in milliseconds
// - stored setting selects operate link rate
// - setup mode forces 115.2 kilobaud rate
// - zero working timeout disables watchdog
// - stored settings load only at power-up
`timescale 1ns/1ps
module iofs_supervisor
  import iofs_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [N_OUT-1:0] i_short_det,
  input wire logic [N_CHIP-1:0] i_ot_warn,
  input wire logic i_field_ok,
  input wire logic i_sep_logic_power,
  input wire logic i_setup_mode,
  output logic [N_OUT-1:0] o_drive,
  output logic o_activity_led,
  output logic o_fault_led,
  output logic [3:0] o_link_rate_index,
  output logic o_field_lost
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  localparam logic [15:0] MS_LAST = 16'(P_MS_CYCLES - 1);

  logic [N_SYNC-1:0] sync_w;
  logic [N_OUT-1:0] short_s;
  logic [N_CHIP-1:0] ot_s;
  logic field_ok_s;
  logic sep_s;
  logic setup_s;

  iofs_sync #(.W(N_SYNC)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_setup_mode, i_sep_logic_power, i_field_ok, i_ot_warn, i_short_det}),
    .o_sync(sync_w)
  );

  assign short_s = sync_w[N_OUT-1:0];
  assign ot_s = sync_w[N_OUT+N_CHIP-1:N_OUT];
  assign field_ok_s = sync_w[N_OUT+N_CHIP];
  assign sep_s = sync_w[N_OUT+N_CHIP+1];
  assign setup_s = sync_w[N_OUT+N_CHIP+2];

  // ****************************************************************
  // wishbone slave decode
  // ****************************************************************
  function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : apply_sel

  logic take;
  logic wr;
  logic fault_clr;
  logic upd;

  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr = take && i_wb_we;
  assign fault_clr = wr && (i_wb_adr == ADDR_FAULT) && i_wb_sel[0] && i_wb_dat[FLT_WDOG];
  assign upd = wr && (i_wb_adr == ADDR_OUT_HI);

  // ****************************************************************
  // power-up load of stored settings
  // ****************************************************************
  iofs_ld_e ld_q;
  logic [15:0] nv_rd_w;
  logic nv_rd_addr;
  logic nv_wr_en;
  logic nv_wr_addr;
  logic [15:0] working_to_q;
  logic [3:0] rate_q;

  assign nv_rd_addr = (ld_q == LD_TO) ? NV_IDX_TO : NV_IDX_RATE;
  // stored writes never touch working copies until the next reset
  assign nv_wr_en = wr && ((i_wb_adr == ADDR_WDT_NV) || (i_wb_adr == ADDR_RATE_NV));
  assign nv_wr_addr = (i_wb_adr == ADDR_RATE_NV) ? NV_IDX_RATE : NV_IDX_TO;

  iofs_nv_store u_nv (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_rd_addr(nv_rd_addr),
    .o_rd_data(nv_rd_w),
    .i_wr_en(nv_wr_en),
    .i_wr_addr(nv_wr_addr),
    .i_wr_data(16'(apply_sel(32'h0000_0000, i_wb_dat, i_wb_sel)))
  );

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ld_q <= LD_TO;
    end else begin
      case (ld_q)
        LD_TO: ld_q <= LD_RATE;
        LD_RATE: ld_q <= LD_LAST;
        LD_LAST: ld_q <= LD_RUN;
        default: ld_q <= LD_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      working_to_q <= WDT_DEF_MS;
    end else if (ld_q == LD_RATE) begin
      working_to_q <= nv_rd_w;
    end else if (wr && (i_wb_adr == ADDR_WDT_WORK)) begin
      working_to_q <= 16'(apply_sel({16'h0000, working_to_q}, i_wb_dat, i_wb_sel));
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rate_q <= NV_RATE_DEF[3:0];
    end else if (ld_q == LD_LAST) begin
      rate_q <= nv_rd_w[3:0];
    end
  end

  // ****************************************************************
  // communication watchdog
  // ****************************************************************
  logic [15:0] tick_cnt_q;
  logic [15:0] ms_elapsed_q;
  logic wdt_expire;

  // saturating elapsed count so a long silence cannot wrap back to ok
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= 16'h0000;
      ms_elapsed_q <= 16'h0000;
    end else if (take) begin
      tick_cnt_q <= 16'h0000;
      ms_elapsed_q <= 16'h0000;
    end else if (tick_cnt_q == MS_LAST) begin
      tick_cnt_q <= 16'h0000;
      if (ms_elapsed_q != 16'hFFFF) begin
        ms_elapsed_q <= ms_elapsed_q + 16'h0001;
      end
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign wdt_expire = (ld_q == LD_RUN) && (working_to_q != 16'h0000) &&
                      (ms_elapsed_q >= working_to_q);

  // ****************************************************************
  // fault latches
  // ****************************************************************
  logic fault_q;
  logic [N_OUT-1:0] short_q;
  logic [N_CHIP-1:0] ot_q;
  logic field_lost_q;
  logic [7:0] fault_byte;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fault_q <= 1'b1;
    end else if (wdt_expire) begin
      fault_q <= 1'b1;
    end else if (fault_clr) begin
      fault_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      short_q <= '0;
      ot_q <= '0;
      field_lost_q <= 1'b0;
    end else begin
      short_q <= short_s | (short_q & ~{N_OUT{fault_clr}});
      ot_q <= ot_s | (ot_q & ~{N_CHIP{fault_clr}});
      field_lost_q <= (sep_s && !field_ok_s) || (field_lost_q && !fault_clr);
    end
  end

  assign fault_byte = {4'h0, field_lost_q, |ot_q, |short_q, fault_q};

  // ****************************************************************
  // output data and drive
  // ****************************************************************
  logic [N_OUT-1:0] out_q;
  logic [N_OUT-1:0] chip_off;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q <= '0;
    end else if (wr && !fault_q) begin
      if (i_wb_adr == ADDR_OUT_LO) begin
        out_q[31:0] <= apply_sel(out_q[31:0], i_wb_dat, i_wb_sel);
      end else if (i_wb_adr == ADDR_OUT_HI) begin
        out_q[N_OUT-1:32] <= 16'(apply_sel({16'h0000, out_q[N_OUT-1:32]}, i_wb_dat, i_wb_sel));
      end
    end
  end

  for (genvar g = 0; g < N_CHIP; g++) begin : g_chip
    assign chip_off[g*CHIP_W +: CHIP_W] = {CHIP_W{ot_q[g]}};
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_drive <= '0;
    end else begin
      o_drive <= out_q & ~short_q & ~chip_off & {N_OUT{!fault_q}};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_field_lost <= 1'b0;
      o_link_rate_index <= NV_RATE_DEF[3:0];
    end else begin
      o_field_lost <= field_lost_q;
      o_link_rate_index <= setup_s ? RATE_SETUP : rate_q;
    end
  end

  // ****************************************************************
  // status indicators
  // ****************************************************************
  logic [15:0] upd_cnt_q;
  logic blink_q;

  // blink follows process updates, not time, so it doubles as a rate check
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      upd_cnt_q <= 16'h0000;
      blink_q <= 1'b0;
    end else if (upd) begin
      if (upd_cnt_q == LED_TOGGLE_UPDATES - 16'h0001) begin
        upd_cnt_q <= 16'h0000;
        blink_q <= !blink_q;
      end else begin
        upd_cnt_q <= upd_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_activity_led <= 1'b0;
      o_fault_led <= 1'b1;
    end else if (setup_s) begin
      o_activity_led <= 1'b1;
      o_fault_led <= 1'b1;
    end else if (fault_q) begin
      o_activity_led <= 1'b0;
      o_fault_led <= 1'b1;
    end else begin
      o_activity_led <= blink_q;
      o_fault_led <= 1'b0;
    end
  end

  // ****************************************************************
  // read mux and acknowledge
  // ****************************************************************
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (i_wb_adr == ADDR_OUT_LO) begin
      rd_d = out_q[31:0];
    end else if (i_wb_adr == ADDR_OUT_HI) begin
      rd_d = {16'h0000, out_q[N_OUT-1:32]};
    end else if (i_wb_adr == ADDR_FAULT) begin
      rd_d = {24'h000000, fault_byte};
    end else if (i_wb_adr == ADDR_STATUS) begin
      rd_d = {20'h00000, ld_q == LD_RUN, setup_s, sep_s, field_ok_s, 2'b00, ot_q};
    end else if (i_wb_adr == ADDR_SHORT_LO) begin
      rd_d = short_q[31:0];
    end else if (i_wb_adr == ADDR_SHORT_HI) begin
      rd_d = {16'h0000, short_q[N_OUT-1:32]};
    end else if (i_wb_adr == ADDR_WDT_WORK) begin
      rd_d = {16'h0000, working_to_q};
    end else if (i_wb_adr == ADDR_RATE_ACT) begin
      rd_d = {28'h0000000, o_link_rate_index};
    end else if (i_wb_adr == ADDR_PD_LO) begin
      rd_d = o_drive[31:0];
    end else if (i_wb_adr == ADDR_PD_HI) begin
      rd_d = {8'h00, fault_byte, o_drive[N_OUT-1:32]};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= take;
      if (take && !i_wb_we) begin
        o_wb_dat <= rd_d;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  wdog_fault_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    wdt_expire |=> fault_q) else $error("watchdog expiry did not latch fault");
  fault_blocks_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    fault_q |=> (o_drive == '0)) else $error("outputs driven while faulted");
  out_write_ignored_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (wr && fault_q) |=> $stable(out_q)) else $error("output write taken while faulted");
  start_faulted_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (ld_q == LD_TO) |-> fault_q) else $error("fault not set after reset");
  short_isolates_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    1'b1 |=> ((o_drive & $past(short_q)) == '0)) else $error("shorted output still driven");
  chip_isolates_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    1'b1 |=> ((o_drive & $past(chip_off)) == '0)) else $error("hot chip output still driven");
  powerup_leds_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (ld_q == LD_TO) |=> (o_fault_led && (!o_activity_led || $past(setup_s))))
    else $error("power-up indicators wrong");
  run_fault_led_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (!setup_s && !fault_q) |=> !o_fault_led) else $error("fault led lit while running");
  setup_leds_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    setup_s |=> (o_activity_led && o_fault_led)) else $error("setup indicators not both on");
  setup_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    setup_s |=> (o_link_rate_index == RATE_SETUP)) else $error("setup rate not forced");
  zero_timeout_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (working_to_q == 16'h0000) |-> !wdt_expire) else $error("watchdog fired with zero timeout");
  access_restart_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    take |=> (ms_elapsed_q == 16'h0000) ##1 (ms_elapsed_q <= 16'h0001))
    else $error("access did not restart watchdog");
  ack_pulse_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    take |=> o_wb_ack ##1 !o_wb_ack) else $error("ack not a single cycle");

endmodule : iofs_supervisor

// File: design/iofs_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module iofs_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : iofs_sync

// File: tb/iofs_field_model.sv
// field side model: driver chips, loads and field supply seen by the card
`timescale 1ns/1ps
module iofs_field_model
  import iofs_pkg::*;
(
  input wire logic i_clock,
  input wire logic [N_OUT-1:0] i_drive,
  input wire logic [N_OUT-1:0] i_short_load,
  input wire logic [N_CHIP-1:0] i_hot_chip,
  input wire logic i_field_on,
  output logic [N_OUT-1:0] o_short_det,
  output logic [N_CHIP-1:0] o_ot_warn,
  output logic o_field_ok
);
  // ****************************************************************
  // load and chip behaviour
  // ****************************************************************
  initial o_short_det = '0;
  // a shorted load only trips while the driver sources into it
  always @(posedge i_clock) begin
    o_short_det <= i_drive & i_short_load;
  end
  assign o_ot_warn = i_hot_chip;
  assign o_field_ok = i_field_on;
endmodule : iofs_field_model

// File: tb/isolated_output_fault_supervisor_tb.sv
// self-checking bench for the output fault supervisor
`timescale 1ns/1ps
module isolated_output_fault_supervisor_tb
  import iofs_pkg::*;
;
  // ****************************************************************
  // wiring
  // ****************************************************************
  localparam logic [47:0] PAT = 48'hC3C3_5A5A_F03C;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic [47:0] drive;
  logic [47:0] sdet;
  logic [47:0] sh_cmd = '0;
  logic [5:0] otw;
  logic [5:0] hot = 6'h00;
  logic act;
  logic flt;
  logic lost;
  logic fok;
  logic fon = 1'b1;
  logic sep = 1'b0;
  logic setup = 1'b0;
  logic [3:0] rate;
  logic a0;
  int n_fail = 0;
  int checks_done = 0;
  always #50 i_clock = ~i_clock;
  iofs_supervisor #(.P_MS_CYCLES(10)) uut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_short_det(sdet), .i_ot_warn(otw),
    .i_field_ok(fok), .i_sep_logic_power(sep), .i_setup_mode(setup), .o_drive(drive),
    .o_activity_led(act), .o_fault_led(flt), .o_link_rate_index(rate), .o_field_lost(lost));
  iofs_field_model field (.i_clock(i_clock), .i_drive(drive), .i_short_load(sh_cmd),
    .i_hot_chip(hot), .i_field_on(fon), .o_short_det(sdet), .o_ot_warn(otw), .o_field_ok(fok));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask : wt
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; the ack is checked to arrive on the second clock edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1);
    chk("ack_latency", 2, n);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_clock);
  endtask : wb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("fault_led", 1, flt);
    chk("act_led", 0, act);
    chk("drive", 0, drive);
    chk("rate", 9, rate);
    rdchk("fault", ADDR_FAULT, 32'h1);
    rdchk("wdt_work", ADDR_WDT_WORK, 32'h32);
    rdchk("nv_wo", ADDR_WDT_NV, 32'h0);
    rdchk("unmapped", 8'hF0, 32'h0);
  endtask : t_reset
  task automatic t_gate();
    wb(1'b1, ADDR_OUT_LO, PAT[31:0]);
    wb(1'b1, ADDR_OUT_HI, {16'h0, PAT[47:32]});
    wt(3);
    chk("drive_faulted", 0, drive);
    wb(1'b1, ADDR_FAULT, 32'h1);
    wt(3);
    chk("drive_cleared", 0, drive);
    chk("fault_led_run", 0, flt);
    wb(1'b1, ADDR_OUT_LO, 32'h5A5A_F0F0);
    sel <= 4'h1;
    wb(1'b1, ADDR_OUT_LO, 32'hFFFF_FF3C);
    sel <= 4'hF;
    wb(1'b1, ADDR_OUT_HI, {16'h0, PAT[47:32]});
    wt(3);
    chk("drive", PAT, drive);
    rdchk("pd_lo", ADDR_PD_LO, PAT[31:0]);
    wb(1'b0, ADDR_PD_HI, 32'h0);
    chk("pd_pad_fault", 16'h0000, rd[31:16]);
    chk("pd_hi", 24'h00C3C3, rd[23:0]);
  endtask : t_gate
  task automatic t_short();
    sh_cmd <= 48'h20;
    wt(8);
    chk("drive_short", PAT & ~48'h20, drive);
    wb(1'b0, ADDR_FAULT, 32'h0);
    chk("short_flag", 1, rd[1]);
    wb(1'b0, ADDR_PD_HI, 32'h0);
    chk("pd_short", 8'h02, rd[23:16]);
    rdchk("short_lo", ADDR_SHORT_LO, 32'h20);
    sh_cmd <= '0;
    wb(1'b1, ADDR_FAULT, 32'h1);
    wt(4);
    chk("drive_back", PAT, drive);
  endtask : t_short
  task automatic t_ot();
    hot <= 6'h04;
    wt(8);
    chk("drive_hot", PAT & ~48'hFF_0000, drive);
    wb(1'b0, ADDR_FAULT, 32'h0);
    chk("ot_flag", 1, rd[2]);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("ot_chip", 6'h04, rd[5:0]);
    hot <= 6'h00;
    wt(4);
    wb(1'b1, ADDR_FAULT, 32'h1);
    wt(4);
    chk("drive_back", PAT, drive);
  endtask : t_ot
  task automatic t_field();
    sep <= 1'b1;
    fon <= 1'b0;
    wt(8);
    chk("field_lost", 1, lost);
    wb(1'b0, ADDR_FAULT, 32'h0);
    chk("field_flag", 1, rd[3]);
    fon <= 1'b1;
    wt(4);
    wb(1'b1, ADDR_FAULT, 32'h1);
    wt(4);
    chk("field_back", 0, lost);
  endtask : t_field
  task automatic t_zero_wdt();
    wb(1'b1, ADDR_WDT_WORK, 32'h0);
    wt(600);
    rdchk("fault_nowd", ADDR_FAULT, 32'h0);
    chk("drive_nowd", PAT, drive);
    wb(1'b1, ADDR_WDT_WORK, 32'h32);
  endtask : t_zero_wdt
  task automatic t_blink();
    int i;
    a0 = act;
    for (i = 0; i < 501 && act === a0; i++) wb(1'b1, ADDR_OUT_HI, {16'h0, PAT[47:32]});
    a0 = act;
    repeat (499) wb(1'b1, ADDR_OUT_HI, {16'h0, PAT[47:32]});
    chk("blink_hold", a0, act);
    wb(1'b1, ADDR_OUT_HI, {16'h0, PAT[47:32]});
    chk("blink_flip", !a0, act);
  endtask : t_blink
  task automatic t_wdog();
    wt(400);
    rdchk("fault_kept", ADDR_FAULT, 32'h0);
    wt(400);
    rdchk("fault_kept", ADDR_FAULT, 32'h0);
    wt(540);
    chk("drive_wd", 0, drive);
    chk("fault_led_wd", 1, flt);
    wb(1'b1, ADDR_OUT_LO, 32'h0000_0000);
    rdchk("out_kept", ADDR_OUT_LO, PAT[31:0]);
    rdchk("fault_latched", ADDR_FAULT, 32'h1);
    wt(3);
    chk("drive_wd", 0, drive);
  endtask : t_wdog
  task automatic t_nv();
    wb(1'b1, ADDR_WDT_NV, 32'h64);
    wb(1'b1, ADDR_RATE_NV, 32'h3);
    rdchk("wdt_same", ADDR_WDT_WORK, 32'h32);
    chk("rate_same", 9, rate);
    i_rst_b <= 1'b0;
    wt(20);
    i_rst_b <= 1'b1;
    wt(5);
    chk("rate_new", 3, rate);
    rdchk("wdt_new", ADDR_WDT_WORK, 32'h64);
    rdchk("fault_again", ADDR_FAULT, 32'h1);
  endtask : t_nv
  task automatic t_setup();
    setup <= 1'b1;
    wt(5);
    chk("setup_act", 1, act);
    chk("setup_flt", 1, flt);
    chk("setup_rate", 4, rate);
    setup <= 1'b0;
    wt(5);
    chk("op_rate", 3, rate);
  endtask : t_setup
  // ****************************************************************
  // sequence and watchdog
  // ****************************************************************
  initial begin
    wt(20);
    i_rst_b <= 1'b1;
    wt(4);
    t_reset();
    t_gate();
    t_short();
    t_ot();
    t_field();
    t_zero_wdt();
    t_blink();
    t_wdog();
    t_nv();
    t_setup();
    end_sim();
  end
  // hang guard, well above the few thousand cycles the run needs
  initial begin
    wt(20000);
    n_fail++;
    end_sim();
  end
endmodule : isolated_output_fault_supervisor_tb
